// ===== design/counter_status_regs.svh
// register offsets, reset values and one-hot command codes of the status block
`ifndef COUNTER_STATUS_REGS_SVH
`define COUNTER_STATUS_REGS_SVH
`define STATUS_OFFSET 8'h00
`define COMMAND_OFFSET 8'h04
`define STATUS_RESET 16'h0000
`define COMMAND_RESET 16'h0000
`define COMMAND_MASK 16'h037F
`define CMD_NONE 6'h00
`define CMD_LOAD_COUNT 6'h01
`define CMD_WRITE_SET2 6'h02
`define CMD_WRITE_SET1 6'h04
`define CMD_READ_COUNT 6'h08
`define CMD_READ_SET2 6'h10
`define CMD_READ_SET1 6'h20
`define CMD_WRITES 6'h07
`define CMD_READS 6'h38
`define SYNC_DEPTH 2
`endif

// ===== design/counter_status_pkg.sv
// types shared by the counter status word logic
package counter_status_pkg;
   typedef struct packed {
      logic [1:0] reserved;
      logic setError;
      logic overUnder;
      logic extInput;
      logic encZ;
      logic cmp2;
      logic cmp1;
      logic counting;
      logic storedCount;
      logic storedSet2;
      logic storedSet1;
      logic dataHex;
      logic doneCount;
      logic doneSet2;
      logic doneSet1;
   } status_word_t;
   typedef struct packed {
      logic [5:0] unusedHigh;
      logic enableOut2;
      logic enableOut1;
      logic unused7;
      logic readCount;
      logic readSet2;
      logic readSet1;
      logic codeHex;
      logic loadCount;
      logic writeSet2;
      logic writeSet1;
   } command_word_t;
   typedef enum logic [1:0] {
      IDLE = 2'b01,
      BUSY = 2'b10
   } engine_state_t;
endpackage

// ===== design/counter_status_word_logic.sv
// status word, command arbitration and wishbone registers of a pulse counter
//
// Our own choices: the Wishbone interface to the registers and the address map.
`include "counter_status_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module counter_status_word_logic (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // counter core handshake
   output logic [5:0] cmdSel,
   output counter_status_pkg::command_word_t cmdWord,
   input wire logic cmdDone,
   input wire logic cmdErr,
   // counter core state
   input wire logic countRun,
   input wire logic overUnderEvent,
   input wire logic cmpOut1,
   input wire logic cmpOut2,
   output logic haltCount,
   // pins
   input wire logic encZPin,
   input wire logic extInPin,
   // status word
   output counter_status_pkg::status_word_t status
);
   // lowest index is the highest priority
   function automatic logic [5:0] pickFirst(input logic [5:0] v);
      logic [5:0] r;
      r = `CMD_NONE;
      for (int i = 5; i >= 0; i--)
      begin
         if (v[i])
         begin
            r = 6'(6'h01 << i);
         end
      end
      return r;
   endfunction

   // bits of lower priority than a one-hot selection
   function automatic logic [5:0] lowerThan(input logic [5:0] s);
      return ~(s | 6'(s - 6'h01));
   endfunction

   function automatic logic [5:0] requests(
      input counter_status_pkg::command_word_t c);
      return {c.readSet1, c.readSet2, c.readCount,
              c.writeSet1, c.writeSet2, c.loadCount};
   endfunction

   logic [`SYNC_DEPTH-1:0] zSync;
   logic [`SYNC_DEPTH-1:0] extSync;
   counter_status_pkg::engine_state_t state;
   counter_status_pkg::engine_state_t next_state;
   logic [5:0] next_cmdSel;
   logic [5:0] doneFlag;
   logic [5:0] next_doneFlag;
   logic setError;
   logic next_setError;
   logic dataHex;
   logic next_dataHex;
   logic next_haltCount;
   logic countRunPrev;
   logic [5:0] pending;
   logic [5:0] finished;
   counter_status_pkg::status_word_t next_status;
   counter_status_pkg::command_word_t next_cmdWord;
   logic next_ack;
   logic [31:0] next_dat;
   logic request;

   // pin synchronisers, only the last stage is read
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         zSync <= '0;
         extSync <= '0;
      end
      else
      begin
         zSync <= {zSync[0], encZPin};
         extSync <= {extSync[0], extInPin};
      end
   end

   // command arbitration and completion flags
   always_comb
   begin
      pending = requests(cmdWord) & ~doneFlag;
      finished = (state == counter_status_pkg::BUSY && cmdDone) ?
                 cmdSel : `CMD_NONE;
      next_state = state;
      next_cmdSel = cmdSel;
      unique case (state)
         counter_status_pkg::IDLE:
         begin
            if (pending != `CMD_NONE)
            begin
               next_cmdSel = pickFirst(pending);
               next_state = counter_status_pkg::BUSY;
            end
         end
         counter_status_pkg::BUSY:
         begin
            if (cmdDone)
            begin
               next_cmdSel = `CMD_NONE;
               next_state = counter_status_pkg::IDLE;
            end
         end
      endcase
      // set wins over a drop or a higher-priority clear in the same cycle
      next_doneFlag = (doneFlag & requests(cmdWord)) | finished;
      if (finished != `CMD_NONE)
      begin
         next_doneFlag = next_doneFlag & ~lowerThan(finished);
      end
      next_setError = setError;
      if ((finished & `CMD_WRITES) != `CMD_NONE)
      begin
         next_setError = cmdErr;
      end
      next_dataHex = dataHex;
      if ((finished & `CMD_READS) != `CMD_NONE)
      begin
         next_dataHex = cmdWord.codeHex;
      end
      // a new event wins over the restart clear
      next_haltCount = overUnderEvent |
                       (haltCount & ~(countRun & ~countRunPrev));
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         state <= counter_status_pkg::IDLE;
         cmdSel <= `CMD_NONE;
         doneFlag <= `CMD_NONE;
         setError <= 1'b0;
         dataHex <= 1'b0;
         haltCount <= 1'b0;
         countRunPrev <= 1'b0;
      end
      else
      begin
         state <= next_state;
         cmdSel <= next_cmdSel;
         doneFlag <= next_doneFlag;
         setError <= next_setError;
         dataHex <= next_dataHex;
         haltCount <= next_haltCount;
         countRunPrev <= countRun;
      end
   end

   // status word, built from the next flag values so it tracks them
   always_comb
   begin
      next_status.reserved = 2'h0;
      next_status.setError = next_setError;
      next_status.overUnder = next_haltCount;
      next_status.extInput = extSync[1];
      next_status.encZ = zSync[1];
      next_status.cmp2 = cmpOut2 & cmdWord.enableOut2;
      next_status.cmp1 = cmpOut1 & cmdWord.enableOut1;
      next_status.counting = countRun;
      next_status.storedCount = next_doneFlag[3];
      next_status.storedSet2 = next_doneFlag[4];
      next_status.storedSet1 = next_doneFlag[5];
      next_status.dataHex = next_dataHex;
      next_status.doneCount = next_doneFlag[0];
      next_status.doneSet2 = next_doneFlag[1];
      next_status.doneSet1 = next_doneFlag[2];
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         status <= `STATUS_RESET;
      end
      else
      begin
         status <= next_status;
      end
   end

   // wishbone slave: ack one cycle after the strobe, write at the ack edge
   always_comb
   begin
      request = wb_cyc_i & wb_stb_i;
      next_ack = request & ~wb_ack_o;
      next_dat = wb_dat_o;
      if (next_ack && !wb_we_i)
      begin
         if (wb_adr_i == `STATUS_OFFSET)
         begin
            next_dat = {16'h0000, status};
         end
         else if (wb_adr_i == `COMMAND_OFFSET)
         begin
            next_dat = {16'h0000, cmdWord};
         end
         else
         begin
            next_dat = 32'h00000000;
         end
      end
      next_cmdWord = cmdWord;
      if (request && wb_ack_o && wb_we_i && wb_adr_i == `COMMAND_OFFSET)
      begin
         // unused command bits never store, so they read back as zero
         if (wb_sel_i[0])
         begin
            next_cmdWord[7:0] = wb_dat_i[7:0] & 8'(`COMMAND_MASK);
         end
         if (wb_sel_i[1])
         begin
            next_cmdWord[15:8] = wb_dat_i[15:8] & 8'(`COMMAND_MASK >> 8);
         end
      end
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         cmdWord <= `COMMAND_RESET;
      end
      else
      begin
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
         cmdWord <= next_cmdWord;
      end
   end

   // checks run on mclk and rest while reset is high
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);

   a_set1_done: assert property (finished == `CMD_WRITE_SET1 |=> status.doneSet1)
      else $error("set value 1 completion flag not set");
   a_set2_done: assert property (finished == `CMD_WRITE_SET2 |=> status.doneSet2)
      else $error("set value 2 completion flag not set");
   a_load_hold: assert property (status.doneCount && cmdWord.loadCount |=> status.doneCount)
      else $error("count load flag cleared while request held");
   a_error_flag: assert property ((finished & `CMD_WRITES) != `CMD_NONE |=> status.setError == $past(cmdErr))
      else $error("setting error flag wrong after update");
   a_higher_clears: assert property (finished == `CMD_LOAD_COUNT |=> !status.doneSet1 && !status.storedSet1)
      else $error("lower flag survived higher command");
   a_count_stored: assert property (finished == `CMD_READ_COUNT |=> status.storedCount)
      else $error("count stored flag not set");
   a_cmp_gate: assert property (!cmdWord.enableOut1 |=> !status.cmp1)
      else $error("compare 1 flag shown while disabled");
   a_encz_track: assert property (##3 status.encZ == $past(encZPin, 3))
      else $error("encoder index flag does not follow pin");
   a_ovf_halt: assert property (overUnderEvent |=> haltCount && status.overUnder)
      else $error("under or overflow did not halt");
   a_restart_clear: assert property ($rose(countRun) && !overUnderEvent |=> !haltCount)
      else $error("restart did not clear the halt flag");
   a_priority_pick: assert property (state == counter_status_pkg::IDLE && pending[0] |=> cmdSel == `CMD_LOAD_COUNT)
      else $error("count load not served first");
   a_reserved_zero: assert property (status.reserved == 2'h0)
      else $error("reserved status bits not zero");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
endmodule
`default_nettype wire

// ===== testbench/counter_core_model.sv
// behavioural counter core behind the status block
`timescale 1ns/1ns
`default_nettype none
module counter_core_model (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // command handshake
   input wire logic [5:0] cmdSel,
   input wire logic failNext,
   output logic cmdDone,
   output logic cmdErr,
   // counting state
   input wire logic haltCount,
   output logic countRun
);
   logic [1:0] waitCnt;
   logic haltPrev;
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         waitCnt <= 2'h0;
         cmdDone <= 1'b0;
         cmdErr <= 1'b0;
         countRun <= 1'b0;
         haltPrev <= 1'b0;
      end
      else
      begin
         haltPrev <= haltCount;
         cmdDone <= 1'b0;
         cmdErr <= 1'b0;
         if (cmdSel != 6'h00 && !cmdDone)
            waitCnt <= waitCnt + 2'h1;
         if (waitCnt == 2'h3)
         begin
            waitCnt <= 2'h0;
            cmdDone <= 1'b1;
            cmdErr <= failNext;
         end
         // only a count load restarts a halted count
         if (cmdDone && cmdSel[0])
            countRun <= 1'b1;
         // stop once as the halt flag rises, so a restart is not undone
         else if (haltCount && !haltPrev)
            countRun <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ===== testbench/counter_status_word_logic_tb.sv
// testbench of the counter status word logic
`timescale 1ns/1ns
`default_nettype none
`include "counter_status_regs.svh"
module counter_status_word_logic_tb;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic wbCyc = 1'b0;
   logic wbStb = 1'b0;
   logic wbWe = 1'b0;
   logic [7:0] wbAdr = 8'h00;
   logic [3:0] wbSel = 4'hF;
   logic [31:0] wbDat = 32'h00000000;
   logic [31:0] wbDatO;
   logic wbAck;
   logic [5:0] cmdSel;
   logic cmdDone, cmdErr, countRun, haltCount;
   logic failNext = 1'b0;
   logic overUnderEvent = 1'b0;
   logic cmpOut1 = 1'b0;
   logic cmpOut2 = 1'b0;
   logic encZPin = 1'b0;
   logic extInPin = 1'b0;
   logic [31:0] rdVal;
   int nMismatch = 0;
   int comparisons = 0;
   always #2 mclk = ~mclk;
   counter_status_word_logic dut (
      .mclk(mclk), .reset(reset),
      .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
      .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat),
      .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
      .cmdSel(cmdSel), .cmdWord(), .cmdDone(cmdDone), .cmdErr(cmdErr),
      .countRun(countRun), .overUnderEvent(overUnderEvent),
      .cmpOut1(cmpOut1), .cmpOut2(cmpOut2), .haltCount(haltCount),
      .encZPin(encZPin), .extInPin(extInPin), .status());
   counter_core_model core (
      .mclk(mclk), .reset(reset), .cmdSel(cmdSel),
      .failNext(failNext), .cmdDone(cmdDone), .cmdErr(cmdErr),
      .haltCount(haltCount), .countRun(countRun));
   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         nMismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrapUp;
      if (nMismatch == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // one classic cycle; answer taken at the edge that sees ack
   task automatic bus(input logic we, input logic [7:0] adr,
                      input logic [31:0] wd);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= adr;
      wbSel <= 4'hF;
      wbDat <= wd;
      @(posedge mclk);
      while (wbAck !== 1'b1)
      begin
         @(posedge mclk);
      end
      rdVal = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rdChk(input logic [7:0] adr, input logic [31:0] exp);
      bus(1'b0, adr, 32'h00000000);
      check("readback", rdVal, exp);
   endtask
   task automatic waitDone;
      @(posedge mclk);
      while (cmdDone !== 1'b1)
      begin
         @(posedge mclk);
      end
      repeat (3) @(posedge mclk);
   endtask
   initial
   begin
      repeat (20000) @(posedge mclk);
      nMismatch++;
      wrapUp;
   end
   initial
   begin
      repeat (5) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      bus(1'b1, 8'h00, 32'h0000FFFF);
      rdChk(8'h00, 32'h00000000);
      rdChk(8'h08, 32'h00000000);
      bus(1'b1, 8'h04, 32'h00000001);
      waitDone;
      rdChk(8'h00, 32'h00000001);
      bus(1'b1, 8'h04, 32'h00000000);
      rdChk(8'h00, 32'h00000000);
      failNext <= 1'b1;
      bus(1'b1, 8'h04, 32'h00000002);
      waitDone;
      rdChk(8'h00, 32'h00002002);
      failNext <= 1'b0;
      bus(1'b1, 8'h04, 32'h00000000);
      rdChk(8'h00, 32'h00002000);
      bus(1'b1, 8'h04, 32'h00000004);
      waitDone;
      rdChk(8'h00, 32'h00000084);
      bus(1'b1, 8'h04, 32'h0000005C);
      while (cmdSel === 6'h00)
         @(posedge mclk);
      check("first served", {26'h0, cmdSel}, {26'h0, `CMD_READ_COUNT});
      waitDone;
      waitDone;
      rdChk(8'h00, 32'h000000DC);
      bus(1'b1, 8'h04, 32'h0000001C);
      rdChk(8'h00, 32'h0000009C);
      bus(1'b1, 8'h04, 32'h00000024);
      waitDone;
      rdChk(8'h00, 32'h000000A4);
      bus(1'b1, 8'h04, 32'h00000000);
      rdChk(8'h00, 32'h00000080);
      cmpOut1 <= 1'b1;
      cmpOut2 <= 1'b1;
      encZPin <= 1'b1;
      bus(1'b1, 8'h04, 32'h00000100);
      repeat (4) @(posedge mclk);
      rdChk(8'h00, 32'h00000580);
      encZPin <= 1'b0;
      extInPin <= 1'b1;
      cmpOut1 <= 1'b0;
      bus(1'b1, 8'h04, 32'h00000300);
      repeat (4) @(posedge mclk);
      rdChk(8'h00, 32'h00000A80);
      overUnderEvent <= 1'b1;
      @(posedge mclk);
      overUnderEvent <= 1'b0;
      repeat (4) @(posedge mclk);
      rdChk(8'h00, 32'h00001A00);
      check("halt", {31'h0, haltCount}, 32'h00000001);
      bus(1'b1, 8'h04, 32'h00000304);
      waitDone;
      rdChk(8'h00, 32'h00000A84);
      check("halt", {31'h0, haltCount}, 32'h00000000);
      rdChk(8'h04, 32'h00000304);
      wrapUp;
   end
endmodule
`default_nettype wire
